// ===== accel_cfg_consts.svh
// Register indices, field positions, reset values and limits of the output path
`ifndef ACCEL_CFG_CONSTS_SVH
`define ACCEL_CFG_CONSTS_SVH

// Register indices; byte address is four times the index
`define DATA_RANGE_IDX 8'h0E
`define HP_CUTOFF_IDX 8'h0F
`define ORIENT_STATUS_IDX 8'h10
`define ORIENT_CFG_IDX 8'h11
`define SYSTEM_MODE_IDX 8'h2A

// Reset values
`define DATA_RANGE_RESET 8'h00
`define HP_CUTOFF_RESET 8'h00
`define ORIENT_CFG_RESET 8'h00
`define SYSTEM_MODE_RESET 8'h00

// Field positions
`define HPF_OUT_BIT 4
`define RANGE_MSB 1
`define RANGE_LSB 0
`define PULSE_HPF_BYP_BIT 5
`define PULSE_LPF_EN_BIT 4
`define CUTOFF_MSB 1
`define CUTOFF_LSB 0
`define ORIENT_ON_BIT 6
`define ACTIVE_BIT 0
`define ODR_MSB 3
`define ODR_LSB 1
`define POWER_MSB 5
`define POWER_LSB 4
`define CHANGED_BIT 7
`define LOCKOUT_BIT 6
`define CODE_MSB 2
`define CODE_LSB 1
`define BACK_BIT 0

// Write masks of implemented bits
`define DATA_RANGE_MASK 8'h13
`define HP_CUTOFF_MASK 8'h33
`define ORIENT_CFG_MASK 8'h40
`define SYSTEM_MODE_MASK 8'h3F

// Sensitivity in micro-g per count
`define SENS_UG_2G 10'h0F4
`define SENS_UG_4G 10'h1E8
`define SENS_UG_8G 10'h3D0
`define SENS_UG_RSVD 10'h000

// 1.25 g in counts at the 2 g range; halves with each range step
`define HOLD_COUNTS_2G 14'h1400

// High-pass state arithmetic
`define HPF_FRAC 10
`define HPF_SHIFT_BASE 5'h02

`endif

// ===== accel_cfg_pkg.sv
// Types shared by the output path configuration and orientation status logic
package accel_cfg_pkg;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_LOW_NOISE_LOW_POWER = 2'b01,
    PWR_HIGH_RES = 2'b10,
    PWR_LOW_POWER = 2'b11
  } power_mode_e;

  typedef enum logic [2:0] {
    ODR_800 = 3'b000,
    ODR_400 = 3'b001,
    ODR_200 = 3'b010,
    ODR_100 = 3'b011,
    ODR_50 = 3'b100,
    ODR_12P5 = 3'b101,
    ODR_6P25 = 3'b110,
    ODR_1P56 = 3'b111
  } odr_e;

  typedef enum logic [1:0] {
    PORTRAIT_UP = 2'b00,
    PORTRAIT_DOWN = 2'b01,
    LANDSCAPE_RIGHT = 2'b10,
    LANDSCAPE_LEFT = 2'b11
  } orient_code_e;

  typedef logic signed [13:0] sample_t;
  typedef logic [2:0][13:0] axes_t;

endpackage

// ===== orient_if.sv
// Signals between the register front end and the orientation status tracker
`timescale 1ns/100ps
interface orient_if;
  import accel_cfg_pkg::*;
  logic detect_done;
  logic detect_on;
  logic active;
  logic hold;
  logic read_clear;
  orient_code_e raw_code;
  logic raw_back;
  logic raw_lockout;
  logic changed;
  orient_code_e code;
  logic back;
  logic lockout;

  modport tracker (
    input detect_done, detect_on, active, hold, read_clear,
    input raw_code, raw_back, raw_lockout,
    output changed, code, back, lockout
  );
  modport ctrl (
    output detect_done, detect_on, active, hold, read_clear,
    output raw_code, raw_back, raw_lockout,
    input changed, code, back, lockout
  );
endinterface

// ===== orient_status_tracker.sv
// Orientation status fields and change flag
`timescale 1ns/100ps
module orient_status_tracker (
  input wire logic clk,
  input wire logic rstn,
  orient_if.tracker oif
);
  import accel_cfg_pkg::*;

  logic prev_active;
  logic first_pending;
  logic take;
  logic differs;
  logic next_changed;

  // Detection results count only while enabled and active [RULE18]
  assign take = oif.detect_done & oif.detect_on & oif.active;
  assign differs = (oif.raw_code != oif.code) | (oif.raw_back != oif.back) |
                   (oif.raw_lockout != oif.lockout);
  // Held orientation yields no change; first result always flags
  assign next_changed = take & (first_pending | (~oif.hold & differs));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_active <= 1'b0;
    end else begin
      prev_active <= oif.active;
    end
  end

  // Armed by each standby to active step [RULE11]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_pending <= 1'b0;
    end else if (oif.active && !prev_active) begin
      first_pending <= 1'b1;
    end else if (take) begin
      first_pending <= 1'b0;
    end
  end

  // Undefined fields come up as zero, lockout shows none [RULE15]
  // Fields follow detection even while the flag is set [RULE16]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oif.code <= PORTRAIT_UP;
      oif.back <= 1'b0;
      oif.lockout <= 1'b0;
    end else if (take && !oif.hold) begin // [RULE17]
      oif.code <= oif.raw_code; // [RULE13]
      oif.back <= oif.raw_back; // [RULE14]
      oif.lockout <= oif.raw_lockout; // [RULE12]
    end
  end

  // Set wins over a read clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oif.changed <= 1'b0;
    end else if (next_changed) begin
      oif.changed <= 1'b1; // [RULE10] [RULE11]
    end else if (oif.read_clear) begin
      oif.changed <= 1'b0; // [RULE8]
    end
  end

endmodule

// ===== accel_output_config.sv
// Output path configuration, filters and orientation status over AHB-Lite
//
// Contract
// RULE1: Output high-pass enable filters output samples
// RULE2: Range field gives 0.244/0.488/0.976 mg per count
// RULE3: Tap highpass skip bit bypasses pulse HPF
// RULE4: Tap lowpass bit enables pulse LPF
// RULE5: Cutoff field gives 16/8/4/2 Hz at 800
// RULE6: Cutoff scales with rate except high resolution
// RULE7: Six orientations: portrait, landscape, face up/down
// RULE8: Status read clears orientation change flag
// RULE9: Change flag sits in status bit 7
// RULE10: Flag sets on face, code or lockout change
// RULE11: First detection after activation sets flag
// RULE12: Lockout bit shows Z-tilt trip exceeded
// RULE13: Code 00 up, 01 down, 10 right, 11 left
// RULE14: Face bit 0 front, 1 back
// RULE15: Power-up shows no lockout
// RULE16: Fields keep tracking while flag is set
// RULE17: Orientation holds when any axis exceeds 1.25 g
// RULE18: Updates only while detection enable is set
// RULE19: Status register writes are ignored
// RULE20: Host never programs reserved range code 11
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "accel_cfg_consts.svh"
module accel_output_config (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire accel_cfg_pkg::axes_t sample_xyz,
  input wire logic orient_detect_done,
  input wire accel_cfg_pkg::orient_code_e orient_raw_code,
  input wire logic orient_raw_back,
  input wire logic orient_raw_lockout,
  output accel_cfg_pkg::axes_t accel_out,
  output logic accel_out_valid,
  output accel_cfg_pkg::axes_t pulse_data,
  output logic pulse_valid,
  output logic [9:0] sens_ug,
  output logic [3:0] hp_cutoff_div,
  output logic orient_changed,
  output accel_cfg_pkg::orient_code_e orient_code,
  output logic orient_back,
  output logic orient_lockout
);
  import accel_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Cutoff as 16 Hz divided by two to the returned power
  function automatic logic [3:0] cutoff_div(input power_mode_e pm,
                                            input odr_e odr,
                                            input logic [1:0] sel);
    logic [3:0] extra;
    extra = 4'h0;
    case (pm)
      PWR_HIGH_RES: extra = 4'h0; // [RULE6]
      PWR_NORMAL: begin
        case (odr)
          ODR_800, ODR_400: extra = 4'h0;
          ODR_200: extra = 4'h1;
          ODR_100: extra = 4'h2;
          default: extra = 4'h3; // [RULE6]
        endcase
      end
      PWR_LOW_NOISE_LOW_POWER: begin
        case (odr)
          ODR_800, ODR_400: extra = 4'h0;
          ODR_200: extra = 4'h1;
          ODR_100: extra = 4'h2;
          ODR_50: extra = 4'h3;
          ODR_12P5: extra = 4'h5;
          ODR_6P25: extra = 4'h6;
          default: extra = 4'h8;
        endcase
      end
      default: begin
        case (odr)
          ODR_800: extra = 4'h0;
          ODR_400: extra = 4'h1;
          ODR_200: extra = 4'h2;
          ODR_100: extra = 4'h3;
          ODR_50: extra = 4'h4;
          ODR_12P5: extra = 4'h6;
          ODR_6P25: extra = 4'h7;
          default: extra = 4'h9;
        endcase
      end
    endcase
    // 800 Hz gives 16, 8, 4, 2 Hz for codes 0 to 3 [RULE5]
    cutoff_div = extra + {2'b00, sel};
  endfunction

  // Clip a 15-bit signed value to the 14-bit sample range
  function automatic sample_t sat14(input logic signed [14:0] v);
    if (v > 15'sh1FFF) begin
      sat14 = 14'sh1FFF;
    end else if (v < -15'sh2000) begin
      sat14 = -14'sh2000;
    end else begin
      sat14 = v[13:0];
    end
  endfunction

  // Magnitude beyond 1.25 g at the selected range
  function automatic logic over_limit(input sample_t s,
                                      input logic [1:0] range_choice);
    logic [13:0] mag;
    logic [13:0] lim;
    mag = s[13] ? 14'(-s) : 14'(s);
    lim = `HOLD_COUNTS_2G >> range_choice;
    over_limit = (s == -14'sh2000) || (mag > lim);
  endfunction

  // ---------------------------------------------------------------
  // Registers and bus state
  // ---------------------------------------------------------------
  logic [7:0] data_range_config;
  logic [7:0] highpass_cutoff_config;
  logic [7:0] orient_cfg;
  logic [7:0] system_mode;
  logic dp_write;
  logic [7:0] dp_idx;
  logic accept;
  logic mapped;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic hold;
  logic signed [23:0] base [0:2];
  sample_t pulse_prev [0:2];
  logic [4:0] shift;

  orient_if oif ();

  orient_status_tracker u_tracker (
    .clk(clk),
    .rstn(rstn),
    .oif(oif.tracker)
  );

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Zero wait states: read data is captured in the address phase
  assign accept = hsel & hready & htrans[1];
  assign mapped = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
  assign idx = haddr[9:2];

  always_comb begin
    rd_byte = 8'h00;
    if (mapped) begin
      case (idx)
        `DATA_RANGE_IDX: rd_byte = data_range_config;
        `HP_CUTOFF_IDX: rd_byte = highpass_cutoff_config;
        `ORIENT_STATUS_IDX: begin
          rd_byte[`CHANGED_BIT] = oif.changed; // [RULE9]
          rd_byte[`LOCKOUT_BIT] = oif.lockout;
          rd_byte[`CODE_MSB:`CODE_LSB] = oif.code;
          rd_byte[`BACK_BIT] = oif.back;
        end
        `ORIENT_CFG_IDX: rd_byte = orient_cfg;
        `SYSTEM_MODE_IDX: rd_byte = system_mode;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
    end else if (hready) begin
      dp_write <= accept & hwrite & mapped;
      dp_idx <= idx;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // A read of the status register clears the change flag unless a set lands in the same cycle [RULE8]
  assign oif.read_clear = accept & ~hwrite & mapped &
                          (idx == `ORIENT_STATUS_IDX);

  // Status index has no write path [RULE19]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_range_config <= `DATA_RANGE_RESET;
      highpass_cutoff_config <= `HP_CUTOFF_RESET;
      orient_cfg <= `ORIENT_CFG_RESET;
      system_mode <= `SYSTEM_MODE_RESET;
    end else if (dp_write) begin
      case (dp_idx)
        `DATA_RANGE_IDX:
          data_range_config <= hwdata[7:0] & `DATA_RANGE_MASK;
        `HP_CUTOFF_IDX:
          highpass_cutoff_config <= hwdata[7:0] & `HP_CUTOFF_MASK;
        `ORIENT_CFG_IDX:
          orient_cfg <= hwdata[7:0] & `ORIENT_CFG_MASK;
        `SYSTEM_MODE_IDX:
          system_mode <= hwdata[7:0] & `SYSTEM_MODE_MASK;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Range and cutoff decode
  // ---------------------------------------------------------------
  // Reserved range code gives zero sensitivity, host must avoid it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sens_ug <= `SENS_UG_2G;
    end else begin
      case (data_range_config[`RANGE_MSB:`RANGE_LSB])
        2'b00: sens_ug <= `SENS_UG_2G; // [RULE2]
        2'b01: sens_ug <= `SENS_UG_4G; // [RULE2]
        2'b10: sens_ug <= `SENS_UG_8G; // [RULE2]
        default: sens_ug <= `SENS_UG_RSVD; // [RULE20]
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hp_cutoff_div <= 4'h0;
    end else begin
      hp_cutoff_div <= cutoff_div(
        power_mode_e'(system_mode[`POWER_MSB:`POWER_LSB]),
        odr_e'(system_mode[`ODR_MSB:`ODR_LSB]),
        highpass_cutoff_config[`CUTOFF_MSB:`CUTOFF_LSB]); // [RULE5]
    end
  end

  // ---------------------------------------------------------------
  // High-pass and pulse filters
  // ---------------------------------------------------------------
  // Leaky integrator; a longer shift trades settling time for cutoff
  assign shift = {1'b0, hp_cutoff_div} + `HPF_SHIFT_BASE;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        base[i] <= 24'sh000000;
        pulse_prev[i] <= 14'sh0000;
      end
      accel_out <= '0;
      pulse_data <= '0;
      accel_out_valid <= 1'b0;
      pulse_valid <= 1'b0;
    end else begin
      accel_out_valid <= sample_valid;
      pulse_valid <= sample_valid;
      if (!system_mode[`ACTIVE_BIT]) begin
        // Standby restarts the filter from rest
        for (int i = 0; i < 3; i++) begin
          base[i] <= 24'sh000000;
          pulse_prev[i] <= 14'sh0000;
        end
      end else if (sample_valid) begin
        for (int i = 0; i < 3; i++) begin
          sample_t x;
          sample_t hp;
          sample_t pre;
          logic signed [24:0] diff;
          x = sample_t'(sample_xyz[i]);
          diff = {x[13], x, 10'h000} - {base[i][23], base[i]};
          base[i] <= base[i] + 24'(diff >>> shift);
          hp = sat14(15'(x) - 15'(base[i] >>> `HPF_FRAC));
          // [RULE1]
          accel_out[i] <= data_range_config[`HPF_OUT_BIT] ? hp : x;
          // [RULE3]
          pre = highpass_cutoff_config[`PULSE_HPF_BYP_BIT] ? x : hp;
          pulse_prev[i] <= pre;
          // [RULE4]
          pulse_data[i] <= highpass_cutoff_config[`PULSE_LPF_EN_BIT] ?
                           14'((15'(pre) + 15'(pulse_prev[i])) >>> 1) :
                           pre;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Orientation hold and tracker hookup
  // ---------------------------------------------------------------
  // Hold flag follows the last raw sample seen
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold <= 1'b0;
    end else if (sample_valid) begin
      hold <= over_limit(sample_t'(sample_xyz[0]),
                data_range_config[`RANGE_MSB:`RANGE_LSB]) |
              over_limit(sample_t'(sample_xyz[1]),
                data_range_config[`RANGE_MSB:`RANGE_LSB]) |
              over_limit(sample_t'(sample_xyz[2]),
                data_range_config[`RANGE_MSB:`RANGE_LSB]); // [RULE17]
    end
  end

  // Four portrait/landscape codes plus face side [RULE7]
  assign oif.detect_done = orient_detect_done;
  assign oif.detect_on = orient_cfg[`ORIENT_ON_BIT];
  assign oif.active = system_mode[`ACTIVE_BIT];
  assign oif.hold = hold;
  assign oif.raw_code = orient_raw_code;
  assign oif.raw_back = orient_raw_back;
  assign oif.raw_lockout = orient_raw_lockout;

  assign orient_changed = oif.changed;
  assign orient_code = oif.code;
  assign orient_back = oif.back;
  assign orient_lockout = oif.lockout;

endmodule

// ===== accel_output_config_assertions.sv
// Port checker of the output path configuration and orientation status
`timescale 1ns/100ps
module accel_output_config_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic sample_valid,
  input wire logic orient_detect_done,
  input wire logic accel_out_valid,
  input wire logic pulse_valid,
  input wire logic [9:0] sens_ug,
  input wire logic orient_changed,
  input wire accel_cfg_pkg::orient_code_e orient_code,
  input wire logic orient_back,
  input wire logic orient_lockout
);
  import accel_cfg_pkg::*;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_status_read;
    hsel && hready && htrans[1] && !hwrite && haddr == 32'h40;
  endsequence
  sequence s_field_move;
    !$stable({orient_code, orient_back, orient_lockout});
  endsequence
  AST_VALID_NEXT: assert property (sample_valid |=> accel_out_valid && pulse_valid)
    else $error("output valid missing after sample");
  AST_SENS_LEGAL: assert property (sens_ug inside {10'h0F4, 10'h1E8, 10'h3D0, 10'h000})
    else $error("sensitivity outside the range table");
  AST_READ_CLEARS: assert property (s_status_read ##0 !orient_detect_done |=> !orient_changed)
    else $error("change flag survived a status read");
  AST_READ_FIELDS: assert property (s_status_read |=> hrdata[7:0] == {$past(orient_changed), $past(orient_lockout), 3'b000, $past(orient_code), $past(orient_back)})
    else $error("status read data does not match fields");
  AST_FLAG_CAUSE: assert property ($rose(orient_changed) |-> $past(orient_detect_done))
    else $error("change flag rose without a detection");
  AST_CHANGE_FLAGS: assert property (s_field_move |-> orient_changed)
    else $error("field moved without change flag");
  AST_FIELDS_CAUSE: assert property (s_field_move |-> $past(orient_detect_done))
    else $error("field moved without a detection");
  AST_NO_LOCKOUT_RESET: assert property ($rose(rstn) |-> !orient_lockout)
    else $error("lockout shown after reset");
endmodule
bind accel_output_config accel_output_config_checker accel_output_config_checker_i (
  .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .sample_valid,
  .orient_detect_done, .accel_out_valid, .pulse_valid, .sens_ug,
  .orient_changed, .orient_code, .orient_back, .orient_lockout);

// ===== ahb_host_model.sv
// Bus host issuing single-word register transfers
`timescale 1ns/100ps
module ahb_host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // Each phase held until hready; no latency assumed, bench timeout ends hangs
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    #1;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench of the output path configuration block
`timescale 1ns/100ps
module tb_top;
  import accel_cfg_pkg::*;
  logic clk, rstn, hsel, hwrite, hresp, hreadyout, sample_valid;
  logic orient_detect_done, orient_raw_back, orient_raw_lockout;
  logic accel_out_valid, pulse_valid, orient_changed, orient_back;
  logic orient_lockout;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] sens_ug;
  logic [3:0] hp_cutoff_div;
  axes_t sample_xyz, accel_out, pulse_data;
  orient_code_e orient_raw_code, orient_code;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] md [7] = '{8'h01, 8'h2F, 8'h09, 8'h0F, 8'h05, 8'h1B, 8'h33};
  logic [3:0] dv [7] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'h1, 4'h5, 4'h1};
  assign hready = hreadyout;
  accel_output_config accel_output_config_i (.clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
    .sample_xyz(sample_xyz), .orient_detect_done(orient_detect_done),
    .orient_raw_code(orient_raw_code), .orient_raw_back(orient_raw_back),
    .orient_raw_lockout(orient_raw_lockout), .accel_out(accel_out),
    .accel_out_valid(accel_out_valid), .pulse_data(pulse_data),
    .pulse_valid(pulse_valid), .sens_ug(sens_ug),
    .hp_cutoff_div(hp_cutoff_div), .orient_changed(orient_changed),
    .orient_code(orient_code), .orient_back(orient_back),
    .orient_lockout(orient_lockout));
  ahb_host_model ahb_host_model_i (.clk(clk), .hready(hready),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [41:0] e,
                     input logic [41:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb_host_model_i.xfer(a, 1'b1, d, v);
    chk("hresp", 1'b0, hresp);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb_host_model_i.xfer(a, 1'b0, 32'h0, v);
    chk("hrdata", e, v);
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [13:0] v);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_xyz <= {v, v, v};
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
    chk("valid", 2'b11, {accel_out_valid, pulse_valid});
  endtask
  task automatic det(input logic [1:0] c, input logic b, input logic l);
    @(posedge clk);
    orient_detect_done <= 1'b1;
    orient_raw_code <= orient_code_e'(c);
    orient_raw_back <= b;
    orient_raw_lockout <= l;
    @(posedge clk);
    orient_detect_done <= 1'b0;
    settle();
  endtask
  task automatic fld(input logic f, input logic [1:0] c, input logic b,
                     input logic l);
    chk("changed", f, orient_changed);
    chk("code", c, orient_code);
    chk("back", b, orient_back);
    chk("lockout", l, orient_lockout);
  endtask
  // ---------------------------------------------------------------
  // Clock, timeout and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Runs take under 3000 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    sample_xyz = '0;
    orient_detect_done = 1'b0;
    orient_raw_code = PORTRAIT_UP;
    orient_raw_back = 1'b0;
    orient_raw_lockout = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk("sens", 10'h0F4, sens_ug);
    fld(1'b0, 2'b00, 1'b0, 1'b0);
    rd(32'h38, 32'h0);
    rd(32'h3C, 32'h0);
    rd(32'h40, 32'h0);
    rd(32'h48, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(32'h38, i);
      settle();
      chk("sens", 10'h0F4 << i, sens_ug);
      rd(32'h38, i);
    end
    for (int i = 0; i < 7; i++) begin
      wr(32'hA8, md[i]);
      for (int s = 0; s < 4; s++) begin
        wr(32'h3C, s);
        settle();
        chk("cutoff", dv[i] + s, hp_cutoff_div);
      end
    end
    // Standby then active so the filter state starts from zero
    wr(32'hA8, 32'h00);
    wr(32'hA8, 32'h01);
    wr(32'h3C, 32'h10);
    wr(32'h38, 32'h10);
    send(14'd1000);
    send(14'd1000);
    chk("accel_out", {3{14'd750}}, accel_out);
    chk("pulse", {3{14'd875}}, pulse_data);
    wr(32'h3C, 32'h20);
    wr(32'h38, 32'h00);
    send(14'd1000);
    chk("accel_out", {3{14'd1000}}, accel_out);
    chk("pulse", {3{14'd1000}}, pulse_data);
    // Negative input through the output filter, pulse path high-pass only
    wr(32'hA8, 32'h00);
    wr(32'hA8, 32'h01);
    wr(32'h3C, 32'h00);
    wr(32'h38, 32'h10);
    send(-14'sd1000);
    send(-14'sd1000);
    chk("accel_out", {3{-14'sd750}}, accel_out);
    chk("pulse", {3{-14'sd750}}, pulse_data);
    wr(32'h44, 32'h40);
    det(2'b00, 1'b0, 1'b0);
    fld(1'b1, 2'b00, 1'b0, 1'b0);
    rd(32'h40, 32'h80);
    chk("changed", 1'b0, orient_changed);
    for (int i = 0; i < 4; i++) begin
      det(2'(i), !i[0], 1'b0);
      fld(1'b1, 2'(i), !i[0], 1'b0);
    end
    rd(32'h40, 32'h86);
    det(2'b11, 1'b0, 1'b1);
    fld(1'b1, 2'b11, 1'b0, 1'b1);
    rd(32'h40, 32'hC6);
    det(2'b11, 1'b0, 1'b1);
    fld(1'b0, 2'b11, 1'b0, 1'b1);
    wr(32'h40, 32'hFF);
    rd(32'h40, 32'h46);
    send(14'd6000);
    det(2'b00, 1'b0, 1'b0);
    fld(1'b0, 2'b11, 1'b0, 1'b1);
    send(14'd1000);
    det(2'b00, 1'b0, 1'b0);
    fld(1'b1, 2'b00, 1'b0, 1'b0);
    rd(32'h40, 32'h80);
    wr(32'h44, 32'h00);
    det(2'b01, 1'b1, 1'b1);
    fld(1'b0, 2'b00, 1'b0, 1'b0);
    wr(32'h44, 32'h40);
    wr(32'hA8, 32'h00);
    wr(32'hA8, 32'h01);
    det(2'b00, 1'b0, 1'b0);
    fld(1'b1, 2'b00, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
